// ### verilog/rsc_top.sv
/*
  Radio sequence controller: state sequencer, shortcuts, interframe gap,
  strength sampling, device address matcher (order_big clear only) and bit counter behind a
  classic Wishbone slave. It assumes the modem runs on clk_i, so its
  strobes need no synchroniser, and that one bit strobe marks each bit.
*/
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
#(
  parameter int RAMPUP_CYCLES = RAMPUP_CYC_DEF
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire rsc_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Modem side.
  input wire rsc_phy_in_t phy_i,
  output rsc_phy_out_t phy_o,
  // Event pulses for the interconnect.
  output logic [7:0] evt_pulse_o
);

  // Complete state of the block.
  typedef struct packed {
    rsc_state_t state;
    logic [3:0] mode_pend;
    logic [3:0] mode_act;
    logic [1:0] pattern;
    logic order_big;
    logic [4:0] shortcut_enables;
    logic [9:0] gap;
    logic [15:0] bcc;
    logic [7:0] da_en;
    logic [7:0] da_type;
    logic [DA_N-1:0][31:0] dab;
    logic [DA_N-1:0][15:0] match_address_high;
    logic [5:0] payofs;
    logic [CNT_W-1:0] cnt;
    logic [7:0] us_div;
    logic gap_on;
    logic [9:0] gap_cnt;
    logic [9:0] filt;
    logic [6:0] rssi_smp;
    logic rssi_valid;
    logic rssi_busy;
    logic [5:0] rssi_cnt;
    logic in_pkt;
    logic addr_seen;
    logic [6:0] da_idx;
    logic [5:0] da_cnt;
    logic [DA_BITS-1:0] da_sr;
    logic da_flag;
    logic da_cmp;
    logic da_done;
    logic [3:0] da_hit;
    logic bc_run;
    logic [15:0] bc_cnt;
    logic [7:0] evt;
    logic [7:0] pulse;
    rsc_phy_out_t phy;
    logic [31:0] wb_dat;
    logic wb_ack;
  } rsc_regs_t;

  rsc_regs_t st; // Registered state.
  rsc_regs_t next_st; // Next state.
  logic acc; // Bus access accepted this cycle.
  logic wr; // Accepted write.
  logic [7:0] tk; // Tasks fired by this write.
  logic [7:0] clr; // Event bits cleared by this write.
  logic [31:0] wv; // Byte-merged write value.
  logic [31:0] old; // Current value of the addressed register.
  logic us_tick; // One pulse per microsecond.
  logic gap_hold; // Gap still running, first bit must wait.
  logic gap_ok; // Gap setting would be enforced now.
  logic sc_rd; // Ready chains to start.
  logic [2:0] ent; // Entry index from the address.
  logic signed [11:0] diff; // Filter error term.
  logic found; // Some enabled entry matched.
  logic [2:0] fidx; // Lowest matching entry.
  logic [15:0] bc_inc; // Bit count after this bit.

  // Merge write data under byte enables so partial writes keep other lanes.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Current register value, used both for reads and for byte merging.
  always_comb begin
    ent = wb_i.adr[4:2];
    old = 32'h0;
    if (wb_i.adr[7:5] == OFS_DAB_BLK) begin
      old = st.dab[ent];
    end else if (wb_i.adr[7:5] == OFS_DAP_BLK) begin
      old = {16'h0, st.match_address_high[ent]};
    end else begin
      case (wb_i.adr)
        OFS_EVENT: old = {24'h0, st.evt};
        OFS_SHORT: old = {27'h0, st.shortcut_enables};
        OFS_MODE: old = {15'h0, st.order_big, 6'h0, st.pattern, 4'h0, st.mode_pend};
        OFS_GAP: old = {22'h0, st.gap};
        OFS_RSSI: old = {24'h0, st.rssi_valid, st.rssi_smp};
        OFS_STATE: old = {24'h0, st.mode_act, st.state};
        OFS_BCC: old = {16'h0, st.bcc};
        OFS_MATCH_ADDRESS_CONFIG: old = {16'h0, st.da_type, st.da_en};
        OFS_PAYOFS: old = {26'h0, st.payofs};
        OFS_DAHIT: old = {28'h0, st.da_hit};
        // Task register and unmapped offsets read as zero.
        default: old = 32'h0;
      endcase
    end
  end

  // Next-state logic of the whole block.
  always_comb begin
    next_st = st;
    next_st.pulse = 8'h0;
    next_st.wb_ack = 1'b0;
    next_st.phy.pkt_start = 1'b0;
    acc = wb_i.cyc && wb_i.stb && !st.wb_ack;
    wr = acc && wb_i.we;
    wv = merge(old, wb_i.dat, wb_i.sel);
    tk = 8'h0;
    clr = 8'h0;
    us_tick = (st.us_div == 8'(US_CYC - 1));
    gap_hold = st.gap_on && (st.gap_cnt != 10'h0);
    sc_rd = st.shortcut_enables[SC_READY_START];
    diff = 12'h0;
    found = 1'b0;
    fidx = 3'h0;
    bc_inc = st.bc_cnt + 16'h1;
    gap_ok = st.shortcut_enables[SC_END_DISABLE] && (st.shortcut_enables[SC_DIS_TXRAMP] || st.shortcut_enables[SC_DIS_RXRAMP]) &&
             (st.gap >= 10'(TURNAROUND_US));

    // Bus slave: one ack per access, dropped the cycle after.
    if (acc) begin
      next_st.wb_ack = 1'b1;
      next_st.wb_dat = old;
    end
    if (wr) begin
      if (wb_i.adr[7:5] == OFS_DAB_BLK) begin
        next_st.dab[ent] = wv;
      end else if (wb_i.adr[7:5] == OFS_DAP_BLK) begin
        next_st.match_address_high[ent] = wv[15:0];
      end else begin
        case (wb_i.adr)
          OFS_TASK: tk = wb_i.sel[0] ? wb_i.dat[7:0] : 8'h0;
          OFS_EVENT: clr = wb_i.sel[0] ? wb_i.dat[7:0] : 8'h0;
          // Shortcuts and gap are used live by the sequencer.
          OFS_SHORT: next_st.shortcut_enables = wv[4:0];
          OFS_GAP: next_st.gap = wv[9:0];
          OFS_MODE: begin
            // The pending mode, pattern and order_big are written; the mode acts at the next ramp-up, whether a task or a disabled shortcut starts it.
            next_st.mode_pend = wv[MODE_LSB +: 4];
            next_st.pattern = wv[PAT_LSB +: 2];
            next_st.order_big = wv[ORDER_BIT];
          end
          OFS_BCC: next_st.bcc = wv[15:0];
          OFS_MATCH_ADDRESS_CONFIG: begin
            next_st.da_en = wv[7:0];
            next_st.da_type = wv[15:8];
          end
          OFS_PAYOFS: next_st.payofs = wv[5:0];
          // Read-only and unmapped offsets ignore writes.
          default: begin
          end
        endcase
      end
    end

    // Microsecond divider and gap countdown.
    next_st.us_div = us_tick ? 8'h0 : st.us_div + 8'h1;
    if (us_tick && gap_hold) begin
      next_st.gap_cnt = st.gap_cnt - 10'h1;
    end

    // Sequencer. Wrong-state tasks are not blocked, only ignored here.
    case (st.state)
      S_DISABLED: begin
        if (tk[TK_TXRAMP]) begin
          next_st.state = S_TRANSMIT_RAMPUP_STATE;
          next_st.mode_act = st.mode_pend;
          next_st.cnt = CNT_W'(RAMPUP_CYCLES - 1);
        end else if (tk[TK_RXRAMP]) begin
          next_st.state = S_RECEIVE_RAMPUP_STATE;
          next_st.mode_act = st.mode_pend;
          next_st.cnt = CNT_W'(RAMPUP_CYCLES - 1);
        end
      end
      S_TRANSMIT_RAMPUP_STATE, S_RECEIVE_RAMPUP_STATE: begin
        if (st.cnt != '0) begin
          next_st.cnt = st.cnt - CNT_W'(1);
        end else if (!gap_hold) begin
          // First bit waits for the gap so the turnaround is exact.
          next_st.pulse[EV_READY] = 1'b1;
          next_st.gap_on = 1'b0;
          if (st.state == S_TRANSMIT_RAMPUP_STATE) begin
            next_st.state = sc_rd ? S_TX : S_TRANSMIT_IDLE_STATE;
            next_st.phy.pkt_start = sc_rd;
          end else begin
            next_st.state = sc_rd ? S_RX : S_RECEIVE_IDLE_STATE;
            next_st.in_pkt = 1'b0;
          end
        end
      end
      S_TRANSMIT_IDLE_STATE: begin
        if (tk[TK_START]) begin
          next_st.state = S_TX;
          next_st.phy.pkt_start = 1'b1;
        end
      end
      S_RECEIVE_IDLE_STATE: begin
        if (tk[TK_START]) begin
          next_st.state = S_RX;
          next_st.in_pkt = 1'b0;
        end
      end
      S_TX, S_RX: begin
        // Symbols before a preamble are ignored in receive.
        if (st.state == S_RX && phy_i.preamble) begin
          next_st.in_pkt = 1'b1;
        end
        if (st.state == S_RX && st.in_pkt && phy_i.address) begin
          next_st.pulse[EV_ADDRESS] = 1'b1;
          next_st.addr_seen = 1'b1;
          next_st.da_idx = 7'h0;
          next_st.da_cnt = 6'h0;
          next_st.da_done = 1'b0;
        end
        if (tk[TK_STOP]) begin
          next_st.state = (st.state == S_TX) ? S_TRANSMIT_IDLE_STATE : S_RECEIVE_IDLE_STATE;
        end else if (phy_i.last_bit && (st.state == S_TX || st.in_pkt)) begin
          next_st.pulse[EV_END] = 1'b1;
          next_st.addr_seen = 1'b0;
          next_st.in_pkt = 1'b0;
          if (gap_ok) begin
            next_st.gap_on = 1'b1;
            next_st.gap_cnt = st.gap;
          end
          if (st.shortcut_enables[SC_END_DISABLE]) begin
            next_st.state = (st.state == S_TX) ? S_TXDIS : S_RXDIS;
            next_st.cnt = CNT_W'(DISABLE_CYC - 1);
          end else if (st.shortcut_enables[SC_END_START]) begin
            // Stay in the same state for the next packet.
            next_st.phy.pkt_start = (st.state == S_TX);
          end else begin
            next_st.state = (st.state == S_TX) ? S_TRANSMIT_IDLE_STATE : S_RECEIVE_IDLE_STATE;
          end
        end
      end
      S_TXDIS, S_RXDIS: begin
        if (st.cnt != '0) begin
          next_st.cnt = st.cnt - CNT_W'(1);
        end else begin
          next_st.pulse[EV_DISABLED] = 1'b1;
          next_st.state = S_DISABLED;
          if (st.shortcut_enables[SC_DIS_TXRAMP]) begin
            next_st.state = S_TRANSMIT_RAMPUP_STATE;
            next_st.mode_act = st.mode_pend;
            next_st.cnt = CNT_W'(RAMPUP_CYCLES - 1);
          end else if (st.shortcut_enables[SC_DIS_RXRAMP]) begin
            next_st.state = S_RECEIVE_RAMPUP_STATE;
            next_st.mode_act = st.mode_pend;
            next_st.cnt = CNT_W'(RAMPUP_CYCLES - 1);
          end
        end
      end
      default: next_st.state = S_DISABLED;
    endcase

    // Disable task from any active state starts the matching shutdown.
    if (tk[TK_DISABLE] && st.state != S_DISABLED && st.state != S_TXDIS && st.state != S_RXDIS) begin
      next_st.state = (st.state == S_TRANSMIT_RAMPUP_STATE || st.state == S_TRANSMIT_IDLE_STATE || st.state == S_TX) ? S_TXDIS : S_RXDIS;
      next_st.cnt = CNT_W'(DISABLE_CYC - 1);
      next_st.gap_on = 1'b0;
      next_st.addr_seen = 1'b0;
    end

    // Radio enables and the idle transmit bit.
    next_st.phy.tx_on = (next_st.state == S_TRANSMIT_IDLE_STATE) || (next_st.state == S_TX) || (next_st.state == S_TXDIS);
    next_st.phy.rx_on = (next_st.state == S_RECEIVE_IDLE_STATE) || (next_st.state == S_RX);
    if (st.state == S_TRANSMIT_IDLE_STATE || st.state == S_TXDIS) begin
      case (st.pattern)
        PAT_ONES: next_st.phy.idle_bit = 1'b1;
        PAT_ZEROS: next_st.phy.idle_bit = 1'b0;
        default: next_st.phy.idle_bit = !st.phy.idle_bit;
      endcase
    end else begin
      next_st.phy.idle_bit = 1'b1;
    end

    // Strength filter, a shift-by-three single pole on a Q7.3 value.
    // A rising step is rounded up so a steady input settles exactly on its own value.
    diff = $signed({2'b00, phy_i.power, 3'b000}) - $signed({2'b00, st.filt});
    next_st.filt = 10'($signed({2'b00, st.filt}) + ((diff + (diff[11] ? 12'sh0 : 12'sh7)) >>> 3));
    if (tk[TK_RSSI]) begin
      next_st.rssi_busy = 1'b1;
      next_st.rssi_cnt = 6'(RSSI_PERIOD_CYC - 1);
    end else if (st.rssi_busy) begin
      if (st.rssi_cnt == 6'h0) begin
        next_st.rssi_busy = 1'b0;
        next_st.rssi_smp = st.filt[9:3];
        next_st.rssi_valid = (st.state == S_RX);
        next_st.pulse[EV_RSSI] = 1'b1;
      end else begin
        next_st.rssi_cnt = st.rssi_cnt - 6'h1;
      end
    end

    // Device address matcher, fed one received bit at a time while order_big is clear.
    if (st.addr_seen && !st.da_done && !st.da_cmp && phy_i.bit_stb && st.state == S_RX &&
        !st.order_big) begin
      if (st.da_idx == 7'(DA_TYPE_BIT)) begin
        next_st.da_flag = phy_i.rx_bit;
      end
      if (st.da_idx >= {1'b0, st.payofs}) begin
        next_st.da_sr = {phy_i.rx_bit, st.da_sr[DA_BITS-1:1]};
        next_st.da_cnt = st.da_cnt + 6'h1;
        next_st.da_cmp = (st.da_cnt == 6'(DA_BITS - 1));
      end
      if (st.da_idx != 7'h7F) begin
        next_st.da_idx = st.da_idx + 7'h1;
      end
    end
    for (int i = DA_N - 1; i >= 0; i--) begin
      if (st.da_en[i] && st.dab[i] == st.da_sr[31:0] && st.match_address_high[i] == st.da_sr[47:32] &&
          st.da_type[i] == st.da_flag) begin
        found = 1'b1;
        fidx = 3'(i);
      end
    end
    if (st.da_cmp) begin
      next_st.da_cmp = 1'b0;
      next_st.da_done = 1'b1;
      next_st.da_hit = {found, fidx};
      next_st.pulse[EV_DAMATCH] = found;
      next_st.pulse[EV_DAMISS] = !found;
    end

    // Bit counter; it keeps running past a hit so a new compare can hit again.
    if (st.bc_run && phy_i.bit_stb) begin
      next_st.bc_cnt = bc_inc;
      if (bc_inc == st.bcc) begin
        next_st.pulse[EV_BCHIT] = 1'b1;
      end
    end
    if (tk[TK_BIT_COUNTER_START_TASK]) begin
      next_st.bc_run = 1'b1;
      next_st.bc_cnt = 16'h0;
    end
    if (tk[TK_BIT_COUNTER_STOP_TASK] || tk[TK_STOP] || tk[TK_DISABLE] || next_st.pulse[EV_END]) begin
      next_st.bc_run = 1'b0;
      next_st.bc_cnt = 16'h0;
    end

    // Sticky events: a new event wins over a clear in the same cycle.
    next_st.evt = (st.evt & ~clr) | next_st.pulse;
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.state <= S_DISABLED;
      st.payofs <= PAYOFS_RST;
      st.phy.idle_bit <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign wb_dat_o = st.wb_dat;
  assign wb_ack_o = st.wb_ack;
  assign phy_o = st.phy;
  assign evt_pulse_o = st.pulse;

  // Cycles from the end of the eight quiet cycles to the done pulse.
  localparam int RSSI_WAIT = RSSI_PERIOD_CYC - 8;

  // Ramp-up completion leads to ready and transmit idle.
  property p_tx_ready;
    @(posedge clk_i) disable iff (rst_i)
    (st.state == S_TRANSMIT_RAMPUP_STATE && st.cnt == '0 && !gap_hold && !sc_rd && tk == 8'h0) |=>
      (st.state == S_TRANSMIT_IDLE_STATE && st.pulse[EV_READY]);
  endproperty
  a_tx_ready: assert property (p_tx_ready)
    else $error("transmit ramp did not reach idle with ready");

  // Ready to start shortcut enters the packet at once.
  property p_short_start;
    @(posedge clk_i) disable iff (rst_i)
    (st.state == S_RECEIVE_RAMPUP_STATE && st.cnt == '0 && !gap_hold && sc_rd && tk == 8'h0) |=> (st.state == S_RX);
  endproperty
  a_short_start: assert property (p_short_start)
    else $error("ready shortcut did not start reception");

  // Idle transmit bit is one under the default pattern.
  property p_idle_ones;
    @(posedge clk_i) disable iff (rst_i)
    (st.state == S_TRANSMIT_IDLE_STATE && st.pattern == PAT_ONES) |=> phy_o.idle_bit;
  endproperty
  a_idle_ones: assert property (p_idle_ones)
    else $error("idle transmit bit not one");

  // No ready while the gap is still running.
  property p_gap_hold;
    @(posedge clk_i) disable iff (rst_i)
    gap_hold |=> !st.pulse[EV_READY];
  endproperty
  a_gap_hold: assert property (p_gap_hold)
    else $error("ready raised before gap elapsed");

  // Mode is taken from the pending value at a ramp task.
  property p_mode_latch;
    @(posedge clk_i) disable iff (rst_i)
    (st.state == S_DISABLED && tk[TK_RXRAMP] && !tk[TK_TXRAMP]) |=> (st.mode_act == $past(st.mode_pend));
  endproperty
  a_mode_latch: assert property (p_mode_latch)
    else $error("mode not latched at ramp task");

  // Sample appears exactly one period after its start.
  property p_rssi_period;
    @(posedge clk_i) disable iff (rst_i)
    ($rose(st.rssi_busy) && !st.pulse[EV_RSSI]) ##1 (!tk[TK_RSSI])[*8] |->
      ##[RSSI_WAIT:RSSI_WAIT] st.pulse[EV_RSSI];
  endproperty
  a_rssi_period: assert property (p_rssi_period)
    else $error("strength sample late or early");

  // Compare hit raises the hit event on the next cycle.
  property p_bc_hit;
    @(posedge clk_i) disable iff (rst_i)
    (st.bc_run && phy_i.bit_stb && bc_inc == st.bcc && tk == 8'h0 && !phy_i.last_bit) |=>
      (st.pulse[EV_BCHIT] && st.bc_cnt == $past(st.bcc));
  endproperty
  a_bc_hit: assert property (p_bc_hit)
    else $error("bit counter missed its compare");

  // End of packet leaves the counter stopped and cleared.
  property p_bc_clear;
    @(posedge clk_i) disable iff (rst_i)
    st.pulse[EV_END] |-> (!st.bc_run && st.bc_cnt == 16'h0);
  endproperty
  a_bc_clear: assert property (p_bc_clear)
    else $error("bit counter not cleared at end");

  // Match and miss never together, and only once per packet.
  property p_da_once;
    @(posedge clk_i) disable iff (rst_i)
    (st.pulse[EV_DAMATCH] || st.pulse[EV_DAMISS]) |->
      (!(st.pulse[EV_DAMATCH] && st.pulse[EV_DAMISS]) && st.da_done && st.da_hit[3] == st.pulse[EV_DAMATCH]);
  endproperty
  a_da_once: assert property (p_da_once)
    else $error("address report inconsistent");

endmodule // rsc_top

// ### shared/rsc_pkg.sv
/*
  Package of the radio sequence controller: register offsets, field
  positions, timing counts, the state enumeration and the carrier structs.
  It assumes a 250 MHz system clock and a modem on that same clock.
*/
package rsc_pkg;

  // Clock rate and derived microsecond divider.
  localparam int CLK_MHZ = 250;
  localparam int US_CYC = CLK_MHZ;
  // Ramp-up and disable times in microseconds and their cycle counts.
  localparam int RAMPUP_US = 40;
  localparam int RAMPUP_CYC_DEF = RAMPUP_US * CLK_MHZ;
  localparam int DISABLE_US = 6;
  localparam int DISABLE_CYC = DISABLE_US * CLK_MHZ;
  localparam int TURNAROUND_US = RAMPUP_US + DISABLE_US;
  // Strength sample period in nanoseconds, rounded up to whole cycles.
  localparam int RSSI_PERIOD_NS = 250;
  localparam int RSSI_PERIOD_CYC = (RSSI_PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;

  // Register byte offsets.
  localparam logic [7:0] OFS_TASK = 8'h00;
  localparam logic [7:0] OFS_EVENT = 8'h04;
  localparam logic [7:0] OFS_SHORT = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_GAP = 8'h10;
  localparam logic [7:0] OFS_RSSI = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_BCC = 8'h1C;
  localparam logic [7:0] OFS_MATCH_ADDRESS_CONFIG = 8'h20;
  localparam logic [7:0] OFS_PAYOFS = 8'h24;
  localparam logic [7:0] OFS_DAHIT = 8'h28;
  localparam logic [2:0] OFS_DAB_BLK = 3'h2;
  localparam logic [2:0] OFS_DAP_BLK = 3'h3;

  // Task bits of the task register.
  localparam int TK_TXRAMP = 0;
  localparam int TK_RXRAMP = 1;
  localparam int TK_START = 2;
  localparam int TK_STOP = 3;
  localparam int TK_DISABLE = 4;
  localparam int TK_RSSI = 5;
  localparam int TK_BIT_COUNTER_START_TASK = 6;
  localparam int TK_BIT_COUNTER_STOP_TASK = 7;
  // Event bits of the event register.
  localparam int EV_READY = 0;
  localparam int EV_ADDRESS = 1;
  localparam int EV_END = 2;
  localparam int EV_DISABLED = 3;
  localparam int EV_BCHIT = 4;
  localparam int EV_DAMATCH = 5;
  localparam int EV_DAMISS = 6;
  localparam int EV_RSSI = 7;
  // Shortcut bits.
  localparam int SC_READY_START = 0;
  localparam int SC_END_DISABLE = 1;
  localparam int SC_DIS_TXRAMP = 2;
  localparam int SC_DIS_RXRAMP = 3;
  localparam int SC_END_START = 4;
  // Mode register field positions.
  localparam int MODE_LSB = 0;
  localparam int PAT_LSB = 8;
  localparam int ORDER_BIT = 16;
  // Idle pattern encodings.
  localparam logic [1:0] PAT_ONES = 2'h0;
  localparam logic [1:0] PAT_ZEROS = 2'h1;
  // Address matcher geometry.
  localparam int DA_BITS = 48;
  localparam int DA_TYPE_BIT = 6;
  localparam int DA_N = 8;
  localparam logic [5:0] PAYOFS_RST = 6'h10;

  // Sequencer states.
  typedef enum logic [3:0] {
    S_DISABLED, S_RECEIVE_RAMPUP_STATE, S_RECEIVE_IDLE_STATE, S_RX, S_TRANSMIT_RAMPUP_STATE, S_TRANSMIT_IDLE_STATE, S_TX, S_RXDIS, S_TXDIS
  } rsc_state_t;

  // Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } rsc_wb_req_t;

  // Modem to sequencer.
  typedef struct packed {
    logic bit_stb;
    logic rx_bit;
    logic preamble;
    logic address;
    logic last_bit;
    logic [6:0] power;
  } rsc_phy_in_t;

  // Sequencer to modem.
  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic pkt_start;
    logic idle_bit;
  } rsc_phy_out_t;

endpackage

// ### sim/rsc_peer.sv
/*
  Peer radio on the air: sends one framed packet on request or when the
  sequencer starts a transmission. Assumes the sequencer's clock.
*/
`timescale 1ns/1ps
module rsc_peer
  import rsc_pkg::*;
(
  // Clock and request.
  input wire logic clk_i,
  input wire logic go_i,
  // Sequencer side.
  input wire rsc_phy_out_t phy_o,
  output rsc_phy_in_t phy_i
);
  logic [6:0] cnt = 7'h00; // Frame step, zero is idle.
  // A gap after the address leaves the bench time to start the counter.
  // Sixty-four bits carry the flag at bit 6 and 48 address bits after offset 16.
  always_ff @(posedge clk_i) begin
    if (cnt == 7'h00) begin
      cnt <= (go_i || phy_o.pkt_start) ? 7'h01 : 7'h00;
    end else begin
      cnt <= (cnt == 7'h48) ? 7'h00 : cnt + 7'h01;
    end
  end
  // The data line toggles every cycle, so no stale bit looks valid.
  always_comb begin
    phy_i = '0;
    phy_i.power = 7'h2A;
    phy_i.rx_bit = cnt[0];
    phy_i.preamble = (cnt == 7'h01);
    phy_i.address = (cnt == 7'h02);
    phy_i.bit_stb = (cnt > 7'h07) && (cnt < 7'h48);
    phy_i.last_bit = (cnt == 7'h48);
  end
endmodule // rsc_peer

// ### sim/testbench.sv
/*
  Self-checking bench of the sequencer: register rows, then transmit,
  receive, strength and bit counter runs. Assumes the peer model.
*/
`timescale 1ns/1ps
module testbench;
  import rsc_pkg::*;
  logic clk_i, rst_i, wb_ack_o, go, clr;
  rsc_wb_req_t wb_i;
  logic [31:0] wb_dat_o, q;
  rsc_phy_in_t phy_i;
  rsc_phy_out_t phy_o;
  logic [7:0] evt_pulse_o, seen;
  int err_count, checks_done, n;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} rsc_row_t;
  rsc_row_t rows [4];
  rsc_top #(.RAMPUP_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .phy_i(phy_i), .phy_o(phy_o), .evt_pulse_o(evt_pulse_o));
  rsc_peer peer (.clk_i(clk_i), .go_i(go), .phy_o(phy_o), .phy_i(phy_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Events are one-cycle pulses, so they are kept until cleared.
  always @(posedge clk_i) seen <= clr ? 8'h00 : (seen | evt_pulse_o);
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, dat: d, sel: 4'hF};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_i <= '0;
    if (n >= 20) begin
      chk("ack", 32'h1, 32'h0);
      print_verdict;
    end
  endtask
  task automatic tk(input int b);
    wb(1'b1, OFS_TASK, 32'h1 << b);
  endtask
  task automatic evclr;
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask
  task automatic wait_ev(input int b, input int lim);
    int n;
    for (n = 0; n < lim && seen[b] !== 1'b1; n++) @(posedge clk_i);
    chk("event", 32'h1, {31'h0, seen[b]});
    if (seen[b] !== 1'b1) print_verdict;
  endtask
  initial begin
    rst_i = 1'b1; wb_i = '0; go = 1'b0; clr = 1'b0; seen = 8'h00; err_count = 0; checks_done = 0;
    rows[0] = '{OFS_SHORT, 32'hFFFFFFFF, 32'h0000001F};
    rows[1] = '{OFS_GAP, 32'hFFFFFFFF, 32'h000003FF};
    rows[2] = '{8'hFC, 32'hFFFFFFFF, 32'h0};
    rows[3] = '{OFS_SHORT, 32'h0, 32'h0};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("idle_bit", 32'h1, {31'h0, phy_o.idle_bit});
    foreach (rows[i]) begin
      wb(1'b1, rows[i].a, rows[i].w);
      wb(1'b0, rows[i].a, 32'h0);
      chk("reg", rows[i].e, q);
    end
    evclr;
    tk(TK_TXRAMP);
    wait_ev(EV_READY, 200);
    wb(1'b0, OFS_STATE, 32'h0);
    chk("tx_state", 32'(S_TRANSMIT_IDLE_STATE), {28'h0, q[3:0]});
    chk("idle_bit", 32'h1, {31'h0, phy_o.idle_bit});
    // The idle pattern acts live; the bit follows one cycle after the write.
    wb(1'b1, OFS_MODE, 32'(PAT_ZEROS) << PAT_LSB);
    @(posedge clk_i);
    chk("idle_zero", 32'h0, {31'h0, phy_o.idle_bit});
    wb(1'b1, OFS_MODE, 32'h0);
    repeat (2) begin
      evclr;
      tk(TK_START);
      wait_ev(EV_END, 150);
    end
    evclr;
    tk(TK_DISABLE);
    wait_ev(EV_DISABLED, 2000);
    evclr;
    tk(TK_RXRAMP);
    wait_ev(EV_READY, 200);
    chk("rx_on", 32'h1, {31'h0, phy_o.rx_on});
    tk(TK_START);
    tk(TK_RSSI);
    wait_ev(EV_RSSI, 100);
    wb(1'b0, OFS_RSSI, 32'h0);
    chk("rssi_valid", 32'h1, {31'h0, q[7]});
    chk("rssi", 32'h2A, {25'h0, q[6:0]});
    wb(1'b1, OFS_BCC, 32'h4);
    // Entry 3 holds the address that the peer's toggling data line forms.
    wb(1'b1, {OFS_DAB_BLK, 3'h3, 2'h0}, 32'hAAAAAAAA);
    wb(1'b1, {OFS_DAP_BLK, 3'h3, 2'h0}, 32'h0000AAAA);
    wb(1'b1, OFS_MATCH_ADDRESS_CONFIG, 32'h00000008);
    wb(1'b1, OFS_SHORT, 32'h1 << SC_END_START);
    evclr;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    wait_ev(EV_ADDRESS, 20);
    tk(TK_BIT_COUNTER_START_TASK);
    wait_ev(EV_BCHIT, 30);
    wait_ev(EV_END, 100);
    wait_ev(EV_DAMATCH, 1);
    wb(1'b0, OFS_DAHIT, 32'h0);
    chk("da_hit", 32'hB, q);
    wb(1'b1, OFS_MATCH_ADDRESS_CONFIG, 32'h0);
    evclr;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    wait_ev(EV_END, 100);
    wait_ev(EV_DAMISS, 1);
    wb(1'b0, OFS_DAHIT, 32'h0);
    chk("da_miss", 32'h0, q);
    // Ready to start, end to disable and disabled to receive ramp, gap at turnaround.
    wb(1'b1, OFS_GAP, 32'(TURNAROUND_US));
    wb(1'b1, OFS_SHORT, 32'hB);
    evclr;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    wait_ev(EV_END, 100);
    n = 0;
    while (seen[EV_READY] !== 1'b1 && n < 12000) begin
      @(posedge clk_i);
      n++;
    end
    wait_ev(EV_DISABLED, 1);
    wait_ev(EV_READY, 1);
    chk("gap_wait", 32'h1, {31'h0, n >= (TURNAROUND_US - 2) * US_CYC});
    wb(1'b0, OFS_STATE, 32'h0);
    chk("short_state", 32'(S_RX), {28'h0, q[3:0]});
    print_verdict;
  end
endmodule // testbench
